// [shared/dual_adc_pkg.sv]
// constants, register map and mode type for the dual-channel sample output port
package dual_adc_pkg;

    // sample word layout
    localparam int SAMPLE_W           = 10;
    localparam int SAMPLE_BUS_BIT_LSB = 0;
    localparam int SAMPLE_BUS_BIT_MSB = 9;

    // conversion latency in converter clock periods
    localparam int LATENCY_CYCLES     = 5;

    // core clock and indicator lag
    localparam int CORE_CLK_MHZ       = 20;
    localparam int IND_DELAY_NS       = 6;
    localparam int IND_DELAY_RAW      = (IND_DELAY_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int IND_DELAY_CYC      = (IND_DELAY_RAW < 1) ? 1 : IND_DELAY_RAW;

    // register bus
    localparam int APB_AW             = 8;
    localparam int APB_DW             = 32;
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STAT_OFS   = 8'h04;
    localparam logic [7:0] LASTA_OFS  = 8'h08;
    localparam logic [7:0] LASTB_OFS  = 8'h0C;

    // control register fields
    localparam int CTRL_SOFT_SLEEP    = 0;
    localparam int CTRL_SOFT_PDOWN    = 1;
    localparam int CTRL_W             = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // status register fields
    localparam int STAT_SLEEP         = 0;
    localparam int STAT_PDOWN         = 1;
    localparam int STAT_INDICATOR     = 2;
    localparam int STAT_DRIVING       = 3;
    localparam int STAT_TWOS          = 4;

    localparam logic [9:0] SAMPLE_RESET = 10'h000;

    typedef enum logic [2:0] {
        MODE_RUN   = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_PDOWN = 3'b100
    } mode_t;

endpackage

// [hdl/sample_pipeline.sv]
// delay line holding both channels' samples for the conversion latency
`timescale 1ns/1ps
module sample_pipeline
    import dual_adc_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W,
    parameter int DEPTH = LATENCY_CYCLES
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             advance,
    input  wire logic [WIDTH-1:0] firstIn,
    input  wire logic [WIDTH-1:0] secondIn,
    output logic      [WIDTH-1:0] firstOut,
    output logic      [WIDTH-1:0] secondOut
);

    logic [WIDTH-1:0] firstStage_q  [DEPTH];
    logic [WIDTH-1:0] secondStage_q [DEPTH];
    logic [WIDTH-1:0] firstStage_d  [DEPTH];
    logic [WIDTH-1:0] secondStage_d [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            firstStage_d[i]  = firstStage_q[i];
            secondStage_d[i] = secondStage_q[i];
        end
        if (advance) begin
            firstStage_d[0]  = firstIn;
            secondStage_d[0] = secondIn;
            for (int i = 1; i < DEPTH; i++) begin
                firstStage_d[i]  = firstStage_q[i-1];
                secondStage_d[i] = secondStage_q[i-1];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!rst_n) begin
                firstStage_q[i]  <= '0;
                secondStage_q[i] <= '0;
            end else begin
                firstStage_q[i]  <= firstStage_d[i];
                secondStage_q[i] <= secondStage_d[i];
            end
        end
    end

    // oldest entry: the sample taken DEPTH advances before the current one
    assign firstOut  = firstStage_q[DEPTH-1];
    assign secondOut = secondStage_q[DEPTH-1];

endmodule

// [hdl/sample_coder.sv]
// converts an offset-binary sample to the selected output coding
`timescale 1ns/1ps
module sample_coder
    import dual_adc_pkg::*;
(
    input  wire logic [SAMPLE_W-1:0] rawCode,
    input  wire logic                twosComp,
    output logic      [SAMPLE_W-1:0] codedSample
);

    always_comb begin
        codedSample = rawCode;
        // codings differ only in the top bit
        codedSample[SAMPLE_BUS_BIT_MSB] = rawCode[SAMPLE_BUS_BIT_MSB] ^ twosComp;
    end

endmodule

// [hdl/dual_adc_muxed_output_port.sv]
// digital output side of a dual-channel converter with a shared sample bus
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module dual_adc_muxed_output_port
    import dual_adc_pkg::*;
#(
    parameter int LATENCY = LATENCY_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                convClk,
    input  wire logic [SAMPLE_W-1:0] firstChannelCode,
    input  wire logic [SAMPLE_W-1:0] secondChannelCode,
    input  wire logic                formatSel,
    input  wire logic                sleepIn,
    input  wire logic                fullPowerDownInput,
    input  wire logic                outputEnable_n,
    output logic      [SAMPLE_W-1:0] sampleBusOut,
    output logic                     sampleBusOe_n,
    output logic                     channelIndicator,
    input  wire logic [APB_AW-1:0]   paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [APB_DW-1:0]   pwdata,
    output logic      [APB_DW-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr
);

    // converter clock edge detection
    logic                convPrev_q;
    logic                convPrev_d;
    logic                convRise;
    logic                convFall;

    // operating mode
    mode_t               mode_q;
    mode_t               mode_d;
    logic                sleepReq;
    logic                pdownReq;

    // output stage
    logic [SAMPLE_W-1:0] busData_q;
    logic [SAMPLE_W-1:0] busData_d;
    logic                busOe_n_q;
    logic                busOe_n_d;
    logic                indicator_q;
    logic                indicator_d;
    logic [SAMPLE_W-1:0] lastFirst_q;
    logic [SAMPLE_W-1:0] lastFirst_d;
    logic [SAMPLE_W-1:0] lastSecond_q;
    logic [SAMPLE_W-1:0] lastSecond_d;
    logic [SAMPLE_W-1:0] pendingSecond_q;
    logic [SAMPLE_W-1:0] pendingSecond_d;

    // pipeline and coding
    logic                advance;
    logic [SAMPLE_W-1:0] firstRaw;
    logic [SAMPLE_W-1:0] secondRaw;
    logic [SAMPLE_W-1:0] firstCoded;
    logic [SAMPLE_W-1:0] secondCoded;

    // register bus
    logic [CTRL_W-1:0]   ctrl_q;
    logic [CTRL_W-1:0]   ctrl_d;
    logic [APB_DW-1:0]   prdata_q;
    logic [APB_DW-1:0]   prdata_d;
    logic                pready_q;
    logic                pready_d;
    logic                pslverr_q;
    logic                pslverr_d;
    logic                accessPhase;
    logic                accessDone;

    function automatic logic addrMapped(input logic [APB_AW-1:0] addr);
        addrMapped = (addr == CTRL_OFS) || (addr == STAT_OFS) ||
                     (addr == LASTA_OFS) || (addr == LASTB_OFS);
    endfunction

    function automatic logic [APB_DW-1:0] zeroExtSample(input logic [SAMPLE_W-1:0] s);
        zeroExtSample = {{(APB_DW-SAMPLE_W){1'b0}}, s};
    endfunction

    // edge detect, no lag; the indicator_q register gives the one-cycle indicator delay
    always_comb begin
        convPrev_d = convClk;
        convRise   = convClk & ~convPrev_q;
        convFall   = ~convClk & convPrev_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            convPrev_q <= 1'b0;
        end else begin
            convPrev_q <= convPrev_d;
        end
    end

    // mode selection; power-down outranks sleep
    always_comb begin
        sleepReq = sleepIn | ctrl_q[CTRL_SOFT_SLEEP];
        pdownReq = fullPowerDownInput | ctrl_q[CTRL_SOFT_PDOWN];
        mode_d   = mode_q;
        case (mode_q)
            MODE_RUN: begin
                if (pdownReq) begin
                    mode_d = MODE_PDOWN;
                end else if (sleepReq) begin
                    mode_d = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (pdownReq) begin
                    mode_d = MODE_PDOWN;
                end else if (!sleepReq) begin
                    mode_d = MODE_RUN;
                end
            end
            MODE_PDOWN: begin
                if (!pdownReq) begin
                    mode_d = sleepReq ? MODE_SLEEP : MODE_RUN;
                end
            end
            default: begin
                mode_d = MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_q <= MODE_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // both channels sampled together on each converter rising edge in run mode
    assign advance = convRise && (mode_q == MODE_RUN);

    sample_pipeline #(
        .WIDTH (SAMPLE_W),
        .DEPTH (LATENCY)
    ) u_pipe (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .advance   (advance),
        .firstIn   (firstChannelCode),
        .secondIn  (secondChannelCode),
        .firstOut  (firstRaw),
        .secondOut (secondRaw)
    );

    sample_coder u_code_first (
        .rawCode     (firstRaw),
        .twosComp    (formatSel),
        .codedSample (firstCoded)
    );

    // second word comes from the same sample instant as the first
    sample_coder u_code_second (
        .rawCode     (pendingSecond_q),
        .twosComp    (formatSel),
        .codedSample (secondCoded)
    );

    // shared bus multiplexing and indicator
    always_comb begin
        busData_d    = busData_q;
        indicator_d  = indicator_q;
        lastFirst_d  = lastFirst_q;
        lastSecond_d = lastSecond_q;
        pendingSecond_d = pendingSecond_q;
        // enable follows its pin in every mode
        busOe_n_d    = outputEnable_n;
        if (mode_q == MODE_RUN) begin
            if (convRise) begin
                // first channel word, LATENCY periods after its sample
                busData_d   = firstCoded;
                lastFirst_d = firstCoded;
                // latch partner before the delay line shifts
                pendingSecond_d = secondRaw;
                indicator_d = 1'b1;
            end else if (convFall) begin
                // second channel word half a period later
                busData_d    = secondCoded;
                lastSecond_d = secondCoded;
                indicator_d  = 1'b0;
            end
        end
        // sleep and power-down leave data and indicator frozen
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busData_q    <= SAMPLE_RESET;
            busOe_n_q    <= 1'b1;
            indicator_q  <= 1'b0;
            lastFirst_q  <= SAMPLE_RESET;
            lastSecond_q <= SAMPLE_RESET;
            pendingSecond_q <= SAMPLE_RESET;
        end else begin
            busData_q    <= busData_d;
            pendingSecond_q <= pendingSecond_d;
            busOe_n_q    <= busOe_n_d;
            indicator_q  <= indicator_d;
            lastFirst_q  <= lastFirst_d;
            lastSecond_q <= lastSecond_d;
        end
    end

    assign sampleBusOut     = busData_q;
    assign sampleBusOe_n    = busOe_n_q;
    assign channelIndicator = indicator_q;

    // register slave: one wait state, answer in the second access cycle
    assign accessPhase = psel & penable;
    assign accessDone  = accessPhase & pready_q;

    always_comb begin
        ctrl_d    = ctrl_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (accessPhase && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = ~addrMapped(paddr);
            prdata_d  = '0;
            if (!pwrite) begin
                if (paddr == CTRL_OFS) begin
                    prdata_d[CTRL_W-1:0] = ctrl_q;
                end else if (paddr == STAT_OFS) begin
                    prdata_d[STAT_SLEEP]     = (mode_q == MODE_SLEEP);
                    prdata_d[STAT_PDOWN]     = (mode_q == MODE_PDOWN);
                    prdata_d[STAT_INDICATOR] = indicator_q;
                    prdata_d[STAT_DRIVING]   = ~busOe_n_q;
                    prdata_d[STAT_TWOS]      = formatSel;
                end else if (paddr == LASTA_OFS) begin
                    prdata_d = zeroExtSample(lastFirst_q);
                end else if (paddr == LASTB_OFS) begin
                    prdata_d = zeroExtSample(lastSecond_q);
                end
            end
        end
        if (accessDone && pwrite && (paddr == CTRL_OFS)) begin
            ctrl_d = pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q    <= CTRL_RESET;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

endmodule

// [testbench/dual_adc_muxed_output_port_asserts.sv]
// concurrent checks on the shared sample bus port
`timescale 1ns/1ps
module dual_adc_asserts
    import dual_adc_pkg::*;
#(
    parameter int LATENCY = LATENCY_CYCLES
) (
    input wire logic                core_clk,
    input wire logic                rst_n,
    input wire logic                convClk,
    input wire logic                sleepIn,
    input wire logic                fullPowerDownInput,
    input wire logic                outputEnable_n,
    input wire logic [SAMPLE_W-1:0] sampleBusOut,
    input wire logic                sampleBusOe_n,
    input wire logic                channelIndicator,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr
);
    logic runMode_q;
    logic runMode_d;
    // mirrors run mode from the pins alone, ignoring the soft control bits; the mode register lags the pins by one cycle
    always_comb begin
        runMode_d = !(sleepIn || fullPowerDownInput);
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            runMode_q <= 1'b1;
        end else begin
            runMode_q <= runMode_d;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence riseRun;
        $rose(convClk) && runMode_q;
    endsequence
    sequence fallRun;
        $fell(convClk) && runMode_q;
    endsequence
    sequence apbSetup;
        psel && !penable;
    endsequence
    chk_first_rise: assert property (riseRun |=> channelIndicator)
        else $error("indicator not high after converter clock rise");
    chk_second_fall: assert property (fallRun |=> !channelIndicator)
        else $error("indicator not low after converter clock fall");
    chk_mode_frozen: assert property (!runMode_q |=> $stable(sampleBusOut)
        && $stable(channelIndicator)) else $error("outputs moved while not running");
    chk_hold_between: assert property (convClk == $past(convClk)
        |=> $stable(sampleBusOut) && $stable(channelIndicator)) else $error("output moved");
    chk_oe_follow: assert property ($past(rst_n)
        |-> sampleBusOe_n == $past(outputEnable_n)) else $error("bus enable wrong");
    chk_apb_wait: assert property (apbSetup |=> !pready ##1 pready)
        else $error("register answer not after one wait state");
    chk_err_pulse: assert property (pslverr |-> pready ##1 !pslverr)
        else $error("error flag not a one cycle pulse with ready");
    chk_reset_state: assert property (disable iff (1'b0) !rst_n |=> sampleBusOe_n
        && !channelIndicator && sampleBusOut == SAMPLE_RESET) else $error("reset state wrong");
endmodule

bind dual_adc_muxed_output_port dual_adc_asserts #(.LATENCY(LATENCY)) chk (
    .core_clk, .rst_n, .convClk, .sleepIn, .fullPowerDownInput, .outputEnable_n,
    .sampleBusOut, .sampleBusOe_n, .channelIndicator, .psel, .penable, .pready, .pslverr);

// [testbench/capture_model.sv]
// capture logic that sorts bus words into channels by the indicator
`timescale 1ns/1ps
module capture_model
    import dual_adc_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic [SAMPLE_W-1:0] busData,
    input  wire logic                busOe_n,
    input  wire logic                indicator,
    output logic      [SAMPLE_W-1:0] firstWord,
    output logic      [SAMPLE_W-1:0] secondWord
);
    logic [SAMPLE_W-1:0] wireLevel;
    logic [SAMPLE_W-1:0] held;
    logic                indPrev;
    // released bus shows the inverse of its last driven value
    assign wireLevel = busOe_n ? ~held : busData;
    always @(posedge core_clk) begin
        if (!busOe_n) held <= busData;
        indPrev <= indicator;
        if (indicator && !indPrev) firstWord <= wireLevel;
        if (!indicator && indPrev) secondWord <= wireLevel;
    end
endmodule

// [testbench/dual_adc_muxed_output_port_bench.sv]
// self-checking bench for the dual-channel shared sample bus port
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module dual_adc_muxed_output_port_bench
    import dual_adc_pkg::*;
;
    logic core_clk = 0, rst_n = 0, convClk = 0, formatSel = 0, sleepIn = 0;
    logic fullPowerDownInput = 0, outputEnable_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  firstChannelCode = '0, secondChannelCode = '0, capFirst, capSecond;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdData;
    logic [9:0]  sampleBusOut, word1, word2, ea, eb, snapW;
    logic        sampleBusOe_n, channelIndicator, pready, pslverr, ind1, ind2, rdErr, snapI;
    logic [20:0] r, p;
    int          errors = 0, comparisons = 0, cycles = 0;
    logic [20:0] rows [8] = '{{1'b0, 10'h000, 10'h3FF}, {1'b1, 10'h000, 10'h3FF},
        {1'b0, 10'h200, 10'h1FF}, {1'b1, 10'h200, 10'h1FF}, {1'b0, 10'h155, 10'h2AA},
        {1'b1, 10'h2AA, 10'h155}, {1'b1, 10'h3FF, 10'h001}, {1'b0, 10'h123, 10'h0ED}};

    dual_adc_muxed_output_port DUT (.core_clk, .rst_n, .convClk, .firstChannelCode,
        .secondChannelCode, .formatSel, .sleepIn, .fullPowerDownInput, .outputEnable_n,
        .sampleBusOut, .sampleBusOe_n, .channelIndicator, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr);
    capture_model capture (.core_clk, .busData(sampleBusOut), .busOe_n(sampleBusOe_n),
        .indicator(channelIndicator), .firstWord(capFirst), .secondWord(capSecond));

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end

    function automatic logic [9:0] code(input logic [9:0] v, input logic f);
        code = f ? {~v[9], v[8:0]} : v;
    endfunction
    task give_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one converter clock period, capturing both presented words
    task automatic conv(input logic [9:0] a, input logic [9:0] b, input logic f);
        @(posedge core_clk);
        firstChannelCode <= a;
        secondChannelCode <= b;
        formatSel <= f;
        convClk <= 1'b1;
        @(posedge core_clk);
        #1 word1 = sampleBusOut;
        ind1 = channelIndicator;
        @(posedge core_clk);
        convClk <= 1'b0;
        @(posedge core_clk);
        #1 word2 = sampleBusOut;
        ind2 = channelIndicator;
        @(posedge core_clk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        `CHK("oeReset", 1'b1, sampleBusOe_n)
        rst_n <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            r = rows[i % 8];
            conv(r[19:10], r[9:0], r[20]);
            p = (i < 5) ? '0 : rows[(i - 5) % 8];
            ea = code(p[19:10], r[20]);
            eb = code(p[9:0], r[20]);
            `CHK("first", ea, word1)
            `CHK("second", eb, word2)
            `CHK("indHigh", 1'b1, ind1)
            `CHK("indLow", 1'b0, ind2)
            `CHK("capFirst", ea, capFirst)
            `CHK("capSecond", eb, capSecond)
        end
        apb(1'b0, LASTA_OFS, '0);
        `CHK("lastFirst", ea, rdData[9:0])
        apb(1'b0, LASTB_OFS, '0);
        `CHK("lastSecond", eb, rdData[9:0])
        for (int m = 0; m < 2; m++) begin
            @(posedge core_clk);
            if (m == 0) sleepIn <= 1'b1;
            else fullPowerDownInput <= 1'b1;
            apb(1'b0, STAT_OFS, '0);
            `CHK("statMode", 1'b1, rdData[m == 0 ? STAT_SLEEP : STAT_PDOWN])
            `CHK("statDrive", 1'b1, rdData[STAT_DRIVING])
            `CHK("statTwos", formatSel, rdData[STAT_TWOS])
            snapW = sampleBusOut;
            snapI = channelIndicator;
            conv(10'h155, 10'h2AA, 1'b1);
            `CHK("heldRise", snapW, word1)
            `CHK("heldFall", snapW, word2)
            `CHK("heldInd", snapI, ind2)
            @(posedge core_clk);
            sleepIn <= 1'b0;
            fullPowerDownInput <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
        apb(1'b1, CTRL_OFS, 32'h0000_0002);
        apb(1'b0, CTRL_OFS, '0);
        `CHK("ctrl", 32'h0000_0002, rdData)
        apb(1'b1, CTRL_OFS, '0);
        apb(1'b0, 8'h10, '0);
        `CHK("unmappedErr", 1'b1, rdErr)
        `CHK("unmappedData", 32'h0000_0000, rdData)
        outputEnable_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 `CHK("oeOff", 1'b1, sampleBusOe_n)
        @(posedge core_clk);
        outputEnable_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 `CHK("oeOn", 1'b0, sampleBusOe_n)
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 `CHK("resetBus", 10'h000, sampleBusOut)
        `CHK("resetInd", 1'b0, channelIndicator)
        give_verdict();
    end
endmodule
